/* File: rtl/ctc_timer.sv */
/*
 * 16-bit up/down counter with input capture, noise filter and byte-wide access.
 * Assumes MCLK is the system clock; pins and comparator output are asynchronous.
 */
// Chosen here: the register addresses and strobed register access.
`timescale 1ns/1ps

// Notes on behaviour
// RULE1: 16-bit counter counts up, down, or clears.
// RULE2: Flags counter at top and at zero.
// RULE3: High byte via shared holding register.
// RULE4: Clock select zero stops counter only.
// RULE5: Software counter write beats count and clear.
// RULE6: Waveform mode picks clear, up or down.
// RULE7: Overflow flag set where mode decides.
// RULE8: Matching edge copies counter into capture.
// RULE9: Capture flag set with copy; enable gates.
// RULE10: Capture flag clears on service or one.
// RULE11: Capture low read loads holding register.
// RULE12: Capture writable only when it is top.
// RULE13: Software writes capture high before low.
// RULE14: Select bit switches trigger to comparator.
// RULE15: Software clears capture flag after switching.
// RULE16: Same synchroniser; filter adds four cycles; here it adds five.
// RULE17: Capture detection off in capture-top modes.
// RULE18: Capture pin level drives capture logic.
// RULE19: Filter changes after four equal samples.
// RULE20: Filter enable in control B; system clock.
// RULE21: New capture overwrites previous value.
// RULE22: Software flips edge, then clears flag.
// RULE23: Pin edge reaches counter within cycles.
// RULE24: Edge select picks rising or falling.
module ctc_timer
(
    // Clock and reset
    input wire logic MCLK,
    input wire logic RST_B,
    // Register port
    input wire ctc_pkg::ctc_req_s REQ,
    output logic [ctc_pkg::DATA_W-1:0] RDATA,
    // Timer and capture inputs
    input wire logic EXT_COUNT_PIN,
    input wire logic CAPTURE_PIN,
    input wire logic COMPARATOR_OUTPUT,
    // Interrupt requests and service acknowledges
    output logic OVF_IRQ,
    output logic CAPT_IRQ,
    input wire logic OVF_ACK,
    input wire logic CAPT_ACK,
    // Counter indications
    output logic TOP_HIT,
    output logic BOTTOM_HIT
);
    import ctc_pkg::*;

    // ****************************************
    // Decoding helpers
    // ****************************************
    function automatic logic capture_is_top(input logic [3:0] mode);
        capture_is_top = (mode == WM_PFC_CAP) || (mode == WM_PC_CAP) ||
                         (mode == WM_CTC_CAP) || (mode == WM_FAST_CAP);
    endfunction : capture_is_top

    function automatic logic dual_slope(input logic [3:0] mode);
        dual_slope = (mode == WM_PFC_CAP) || (mode == WM_PC_CAP);
    endfunction : dual_slope

    logic [DATA_W-1:0] ctrl_a_reg;
    logic [DATA_W-1:0] ctrl_b_reg;
    logic [DATA_W-1:0] mask_reg;
    logic comp_sel_reg;
    logic [CNT_W-1:0] count_reg;
    logic [CNT_W-1:0] count_next;
    logic [CNT_W-1:0] capt_reg;
    logic [DATA_W-1:0] hold_reg;
    logic [DATA_W-1:0] rdata_reg;
    logic ovf_flag_reg;
    logic capt_flag_reg;
    ctc_dir_e dir_reg;
    ctc_dir_e dir_next;

    // ****************************************
    // Register decode
    // ****************************************
    wire [3:0] wave_mode = {ctrl_b_reg[B_WAVE_HI+1:B_WAVE_HI], ctrl_a_reg[B_WAVE_LO+1:B_WAVE_LO]};
    wire [2:0] clk_sel = ctrl_b_reg[B_CS+2:B_CS];
    wire edge_rising = ctrl_b_reg[B_EDGE];
    wire filter_on = ctrl_b_reg[B_FILTER];
    wire cap_top_mode = capture_is_top(wave_mode);
    wire wr_ctrl_a = REQ.wr && (REQ.addr == OFS_CTRL_A);
    wire wr_ctrl_b = REQ.wr && (REQ.addr == OFS_CTRL_B);
    wire wr_cnt_lo = REQ.wr && (REQ.addr == OFS_CNT_LO);
    wire wr_cnt_hi = REQ.wr && (REQ.addr == OFS_CNT_HI);
    wire wr_cap_lo = REQ.wr && (REQ.addr == OFS_CAP_LO);
    wire wr_cap_hi = REQ.wr && (REQ.addr == OFS_CAP_HI);
    wire wr_flags = REQ.wr && (REQ.addr == OFS_FLAGS);
    wire wr_mask = REQ.wr && (REQ.addr == OFS_MASK);
    wire wr_src = REQ.wr && (REQ.addr == OFS_SRC);
    wire rd_cnt_lo = REQ.rd && (REQ.addr == OFS_CNT_LO);
    wire rd_cap_lo = REQ.rd && (REQ.addr == OFS_CAP_LO);
    wire cap_write_ok = wr_cap_lo && cap_top_mode; // see RULE12

    // ****************************************
    // Input synchronisers
    // ****************************************
    wire [N_INPUTS-1:0] raw_in = {COMPARATOR_OUTPUT, CAPTURE_PIN, EXT_COUNT_PIN}; // see RULE18
    wire [N_INPUTS-1:0] stable_reg;

    genvar gi;
    generate
        for (gi = 0; gi < N_INPUTS; gi++)
        begin : g_sync
            logic [SYNC_STAGES-1:0] sync_reg;
            logic agreed_reg;
            always_ff @(posedge MCLK)
            begin
                if (!RST_B)
                begin
                    sync_reg <= '0;
                    agreed_reg <= 1'b0;
                end
                else
                begin
                    sync_reg <= {sync_reg[SYNC_STAGES-2:0], raw_in[gi]};
                    // Change accepted once the two later stages agree
                    if (sync_reg[SYNC_STAGES-2] == sync_reg[SYNC_STAGES-1])
                    begin
                        agreed_reg <= sync_reg[SYNC_STAGES-1]; // see RULE16
                    end
                end
            end
            assign stable_reg[gi] = agreed_reg;
        end
    endgenerate

    // ****************************************
    // Timer tick
    // ****************************************
    logic ext_prev_reg;
    wire ext_rise = stable_reg[IN_EXT] && !ext_prev_reg;
    wire ext_fall = !stable_reg[IN_EXT] && ext_prev_reg;
    wire timer_tick = (clk_sel == CS_SYSCLK) ||
                      ((clk_sel == CS_EXT_RISE) && ext_rise) ||
                      ((clk_sel == CS_EXT_FALL) && ext_fall); // see RULE4, RULE23

    // ****************************************
    // Capture source, filter and edge detector
    // ****************************************
    wire src_level = comp_sel_reg ? stable_reg[IN_COMP] : stable_reg[IN_PIN]; // see RULE14
    logic [FILTER_SAMPLES-1:0] filt_shift_reg;
    logic filt_out_reg;
    logic det_prev_reg;
    wire det_in = filter_on ? filt_out_reg : src_level; // see RULE20
    wire det_rise = det_in && !det_prev_reg;
    wire det_fall = !det_in && det_prev_reg;
    wire capture_event = !cap_top_mode && (edge_rising ? det_rise : det_fall); // see RULE17, RULE24

    always_ff @(posedge MCLK)
    begin
        if (!RST_B)
        begin
            ext_prev_reg <= 1'b0;
            filt_shift_reg <= '0;
            filt_out_reg <= 1'b0;
            det_prev_reg <= 1'b0;
        end
        else
        begin
            ext_prev_reg <= stable_reg[IN_EXT];
            filt_shift_reg <= {filt_shift_reg[FILTER_SAMPLES-2:0], src_level};
            if (&filt_shift_reg)
            begin
                filt_out_reg <= 1'b1; // see RULE19
            end
            else if (~|filt_shift_reg)
            begin
                filt_out_reg <= 1'b0; // see RULE19
            end
            det_prev_reg <= det_in;
        end
    end

    // ****************************************
    // Counter sequence
    // ****************************************
    wire [CNT_W-1:0] top_value = cap_top_mode ? capt_reg : COUNT_MAX;
    wire at_top = (count_reg == top_value); // see RULE2
    wire at_bottom = (count_reg == COUNT_ZERO); // see RULE2
    wire [CNT_W-1:0] count_inc = CNT_W'(count_reg + COUNT_ONE);
    wire [CNT_W-1:0] count_dec = CNT_W'(count_reg - COUNT_ONE);
    wire ovf_event = timer_tick && !wr_cnt_lo &&
                     (dual_slope(wave_mode) ? (dir_reg == DIR_DOWN) && at_bottom :
                      (wave_mode == WM_FAST_CAP) ? at_top :
                      (count_reg == COUNT_MAX)); // see RULE7

    always_comb
    begin
        count_next = count_reg;
        dir_next = dir_reg;
        if (wr_cnt_lo)
        begin
            count_next = {hold_reg, REQ.wdata}; // see RULE3, RULE5
        end
        else if (timer_tick)
        begin
            if (dual_slope(wave_mode))
            begin
                case (dir_reg)
                    DIR_UP:
                    begin
                        dir_next = at_top ? DIR_DOWN : DIR_UP;
                        count_next = at_top ? count_dec : count_inc; // see RULE1, RULE6
                    end
                    DIR_DOWN:
                    begin
                        dir_next = at_bottom ? DIR_UP : DIR_DOWN;
                        count_next = at_bottom ? count_inc : count_dec; // see RULE1, RULE6
                    end
                    default:
                    begin
                        dir_next = DIR_UP;
                    end
                endcase
            end
            else
            begin
                dir_next = DIR_UP;
                count_next = at_top ? COUNT_ZERO : count_inc; // see RULE1, RULE6
            end
        end
    end

    // ****************************************
    // Registers and flags
    // ****************************************
    always_ff @(posedge MCLK)
    begin
        if (!RST_B)
        begin
            count_reg <= COUNT_ZERO;
            dir_reg <= DIR_UP;
        end
        else
        begin
            count_reg <= count_next;
            dir_reg <= dir_next;
        end
    end

    always_ff @(posedge MCLK)
    begin
        if (!RST_B)
        begin
            capt_reg <= COUNT_ZERO;
        end
        else if (capture_event)
        begin
            capt_reg <= count_reg; // see RULE8, RULE21
        end
        else if (cap_write_ok)
        begin
            capt_reg <= {hold_reg, REQ.wdata}; // see RULE12, RULE13
        end
    end

    always_ff @(posedge MCLK)
    begin
        if (!RST_B)
        begin
            hold_reg <= RESET_BYTE;
        end
        else if (rd_cnt_lo)
        begin
            hold_reg <= count_reg[CNT_W-1:DATA_W]; // see RULE3
        end
        else if (rd_cap_lo)
        begin
            hold_reg <= capt_reg[CNT_W-1:DATA_W]; // see RULE11
        end
        else if (wr_cnt_hi || wr_cap_hi)
        begin
            hold_reg <= REQ.wdata; // see RULE3
        end
    end

    // Set wins over clear for both flags
    wire ovf_clear = OVF_ACK || (wr_flags && REQ.wdata[B_OVF]);
    wire capt_clear = CAPT_ACK || (wr_flags && REQ.wdata[B_CAP]); // see RULE10, RULE15

    always_ff @(posedge MCLK)
    begin
        if (!RST_B)
        begin
            ovf_flag_reg <= 1'b0;
            capt_flag_reg <= 1'b0;
        end
        else
        begin
            ovf_flag_reg <= ovf_event || (ovf_flag_reg && !ovf_clear); // see RULE7
            capt_flag_reg <= capture_event || (capt_flag_reg && !capt_clear); // see RULE9, RULE10
        end
    end

    always_ff @(posedge MCLK)
    begin
        if (!RST_B)
        begin
            ctrl_a_reg <= RESET_BYTE;
            ctrl_b_reg <= RESET_BYTE;
            mask_reg <= RESET_BYTE;
            comp_sel_reg <= 1'b0;
        end
        else
        begin
            ctrl_a_reg <= wr_ctrl_a ? REQ.wdata : ctrl_a_reg;
            ctrl_b_reg <= wr_ctrl_b ? REQ.wdata : ctrl_b_reg;
            mask_reg <= wr_mask ? REQ.wdata : mask_reg;
            comp_sel_reg <= wr_src ? REQ.wdata[B_COMP_SEL] : comp_sel_reg;
        end
    end

    // ****************************************
    // Read path
    // ****************************************
    wire [DATA_W-1:0] flags_byte = DATA_W'({capt_flag_reg, ovf_flag_reg});
    wire [DATA_W-1:0] src_byte = DATA_W'(comp_sel_reg);
    wire [DATA_W-1:0] rd_mux =
        (REQ.addr == OFS_CTRL_A) ? ctrl_a_reg :
        (REQ.addr == OFS_CTRL_B) ? ctrl_b_reg :
        (REQ.addr == OFS_CNT_LO) ? count_reg[DATA_W-1:0] :
        (REQ.addr == OFS_CAP_LO) ? capt_reg[DATA_W-1:0] :
        ((REQ.addr == OFS_CNT_HI) || (REQ.addr == OFS_CAP_HI)) ? hold_reg : // see RULE3, RULE11
        (REQ.addr == OFS_FLAGS) ? flags_byte :
        (REQ.addr == OFS_MASK) ? mask_reg :
        (REQ.addr == OFS_SRC) ? src_byte : RESET_BYTE;

    always_ff @(posedge MCLK)
    begin
        if (!RST_B)
        begin
            rdata_reg <= RESET_BYTE;
        end
        else
        begin
            rdata_reg <= REQ.rd ? rd_mux : RESET_BYTE;
        end
    end

    assign RDATA = rdata_reg;
    assign OVF_IRQ = ovf_flag_reg && mask_reg[B_OVF];
    assign CAPT_IRQ = capt_flag_reg && mask_reg[B_CAP]; // see RULE9
    assign TOP_HIT = at_top;
    assign BOTTOM_HIT = at_bottom;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (!RST_B);

    sequence s_capture_trigger;
        capture_event;
    endsequence

    sequence s_capture_done;
        capt_flag_reg && (capt_reg == $past(count_reg));
    endsequence

    a_capture_copy_flag: assert property (s_capture_trigger |=> s_capture_done) // see RULE8, RULE9
        else $error("capture did not copy counter and set flag");

    a_count_write_wins: assert property (wr_cnt_lo |=> count_reg == {$past(hold_reg), $past(REQ.wdata)}) // see RULE5
        else $error("counter write lost");

    a_stop_holds_count: assert property ((clk_sel == CS_STOP) && !wr_cnt_lo |=> $stable(count_reg)) // see RULE4
        else $error("counter moved while stopped");

    a_single_slope_up: assert property (timer_tick && !wr_cnt_lo && !dual_slope(wave_mode) && !at_top
        |=> count_reg == CNT_W'($past(count_reg) + COUNT_ONE)) // see RULE1
        else $error("counter did not increment");

    a_clear_at_top: assert property (timer_tick && !wr_cnt_lo && !dual_slope(wave_mode) && at_top
        |=> count_reg == COUNT_ZERO) // see RULE6
        else $error("counter did not wrap at top");

    a_low_read_hold: assert property (rd_cnt_lo |=> hold_reg == $past(count_reg[CNT_W-1:DATA_W]) ##1 1'b1) // see RULE3
        else $error("holding register not loaded");

    // Low read, one idle cycle, then the high read
    sequence s_cap_hi_after_lo;
        rd_cap_lo ##1 (!REQ.wr && !REQ.rd) ##1 (REQ.rd && (REQ.addr == OFS_CAP_HI));
    endsequence

    a_capture_hi_read: assert property (s_cap_hi_after_lo |=> RDATA == $past(capt_reg[CNT_W-1:DATA_W], 3)) // see RULE11
        else $error("capture high byte read wrong");

    a_capture_write_block: assert property (wr_cap_lo && !cap_top_mode && !capture_event |=> $stable(capt_reg)) // see RULE12
        else $error("capture written outside capture-top mode");

    a_flag_w1c: assert property (wr_flags && REQ.wdata[B_CAP] && !capture_event |=> !capt_flag_reg) // see RULE10
        else $error("capture flag not cleared");

    a_filter_agree: assert property (filter_on && $changed(filt_out_reg)
        |-> $past(&filt_shift_reg) || $past(~|filt_shift_reg)) // see RULE19
        else $error("filter changed without four equal samples");

    a_no_capture_top: assert property (cap_top_mode |-> !capture_event) // see RULE17
        else $error("capture in capture-top mode");

    a_overflow_normal: assert property ((wave_mode == WM_NORMAL) && timer_tick && !wr_cnt_lo &&
        (count_reg == COUNT_MAX) |=> ovf_flag_reg) // see RULE7
        else $error("overflow flag not set at max");

endmodule : ctc_timer

/* File: rtl/ctc_pkg.sv */
/*
 * Constants, register map and carrier types for the counter with input capture.
 * Assumes an 8-bit register port driven by a single master on the same clock.
 */
package ctc_pkg;

    // ****************************************
    // Register bus
    // ****************************************
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam int CNT_W = 16;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } ctc_req_s;

    localparam logic [ADDR_W-1:0] OFS_CTRL_A = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_CTRL_B = 4'h1;
    localparam logic [ADDR_W-1:0] OFS_CNT_LO = 4'h2;
    localparam logic [ADDR_W-1:0] OFS_CNT_HI = 4'h3;
    localparam logic [ADDR_W-1:0] OFS_CAP_LO = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_CAP_HI = 4'h5;
    localparam logic [ADDR_W-1:0] OFS_FLAGS = 4'h6;
    localparam logic [ADDR_W-1:0] OFS_MASK = 4'h7;
    localparam logic [ADDR_W-1:0] OFS_SRC = 4'h8;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int B_WAVE_LO = 0;
    localparam int B_CS = 0;
    localparam int B_WAVE_HI = 3;
    localparam int B_EDGE = 6;
    localparam int B_FILTER = 7;
    localparam int B_OVF = 0;
    localparam int B_CAP = 1;
    localparam int B_COMP_SEL = 0;

    localparam logic [DATA_W-1:0] RESET_BYTE = 8'h00;
    localparam logic [CNT_W-1:0] COUNT_MAX = 16'hffff;
    localparam logic [CNT_W-1:0] COUNT_ZERO = 16'h0000;
    localparam logic [CNT_W-1:0] COUNT_ONE = 16'h0001;

    // ****************************************
    // Clock select codes
    // ****************************************
    localparam logic [2:0] CS_STOP = 3'h0;
    localparam logic [2:0] CS_SYSCLK = 3'h1;
    localparam logic [2:0] CS_EXT_FALL = 3'h6;
    localparam logic [2:0] CS_EXT_RISE = 3'h7;

    // ****************************************
    // Waveform modes with counting effect
    // ****************************************
    localparam logic [3:0] WM_NORMAL = 4'h0;
    localparam logic [3:0] WM_PFC_CAP = 4'h8;
    localparam logic [3:0] WM_PC_CAP = 4'ha;
    localparam logic [3:0] WM_CTC_CAP = 4'hc;
    localparam logic [3:0] WM_FAST_CAP = 4'he;

    // ****************************************
    // Input conditioning
    // ****************************************
    localparam int SYNC_STAGES = 3;
    localparam int FILTER_SAMPLES = 4;
    localparam int N_INPUTS = 3;
    localparam int IN_EXT = 0;
    localparam int IN_PIN = 1;
    localparam int IN_COMP = 2;

    typedef enum logic {DIR_UP, DIR_DOWN} ctc_dir_e;

endpackage : ctc_pkg

/* File: testbench/ctc_cpu_model.sv */
/*
 * CPU side of the counter: a byte-wide master of the register port with 16-bit helpers.
 * Assumes the slave answers reads in the next cycle and never stalls.
 */
`timescale 1ns/1ps
module ctc_cpu_model
(
    // Clock
    input wire logic MCLK,
    // Register port
    output ctc_pkg::ctc_req_s REQ,
    input wire logic [ctc_pkg::DATA_W-1:0] RDATA
);
    import ctc_pkg::*;

    initial REQ = '0;

    // ****************************************
    // Bus cycles
    // ****************************************
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge MCLK);
        REQ <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge MCLK);
        REQ.wr <= 1'b0;
        #1;
    endtask : wr

    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge MCLK);
        REQ <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge MCLK);
        REQ.rd <= 1'b0;
        #1;
        d = RDATA;
    endtask : rd

    // High byte first so the holding register is loaded before the low write
    task automatic wr16(input logic [ADDR_W-1:0] lo, input logic [CNT_W-1:0] v);
        wr(lo + 4'h1, v[15:8]);
        wr(lo, v[7:0]);
    endtask : wr16

    task automatic rd16(input logic [ADDR_W-1:0] lo, output logic [CNT_W-1:0] v);
        rd(lo, v[7:0]);
        rd(lo + 4'h1, v[15:8]);
    endtask : rd16

    // Discards a capture left behind by a source or edge change
    task automatic clear_flags(input logic [DATA_W-1:0] m);
        wr(OFS_FLAGS, m);
    endtask : clear_flags

endmodule : ctc_cpu_model

/* File: testbench/tb_top.sv */
/*
 * Self-checking bench for the counter with input capture.
 * Assumes the CPU model drives the register port and the bench drives pins and acknowledges.
 */
`timescale 1ns/1ps
module tb_top;
    import ctc_pkg::*;

    logic MCLK = 1'b0;
    logic RST_B = 1'b0;
    ctc_req_s req;
    logic [DATA_W-1:0] rdata;
    logic ext_pin = 1'b0;
    logic cap_pin = 1'b0;
    logic comp_out = 1'b0;
    logic ovf_ack = 1'b0;
    logic capt_ack = 1'b0;
    logic ovf_irq, capt_irq, top_hit, bottom_hit;
    int fails = 0;
    int n_tests = 0;
    logic [15:0] v, t;
    logic [15:0] vals [4];

    always #2 MCLK = ~MCLK;

    ctc_timer dut_u (.MCLK(MCLK), .RST_B(RST_B), .REQ(req), .RDATA(rdata), .EXT_COUNT_PIN(ext_pin),
        .CAPTURE_PIN(cap_pin), .COMPARATOR_OUTPUT(comp_out), .OVF_IRQ(ovf_irq), .CAPT_IRQ(capt_irq),
        .OVF_ACK(ovf_ack), .CAPT_ACK(capt_ack), .TOP_HIT(top_hit), .BOTTOM_HIT(bottom_hit));

    ctc_cpu_model cpu_u (.MCLK(MCLK), .REQ(req), .RDATA(rdata));

    // ****************************************
    // Checking and expectations
    // ****************************************
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            fails++;
            $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic final_report();
        if (fails == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : final_report

    function automatic logic [15:0] pins();
        return {12'h000, top_hit, bottom_hit, ovf_irq, capt_irq};
    endfunction : pins

    function automatic logic [15:0] exp_pins(input logic [15:0] c, input logic [1:0] irq);
        return {12'h000, c == COUNT_MAX, c == COUNT_ZERO, irq};
    endfunction : exp_pins

    task automatic expect8(input logic [ADDR_W-1:0] a, input logic [7:0] e);
        logic [7:0] d;
        cpu_u.rd(a, d);
        check({8'h00, d}, {8'h00, e});
    endtask : expect8

    task automatic expect16(input logic [ADDR_W-1:0] lo, input logic [15:0] e);
        logic [15:0] d;
        cpu_u.rd16(lo, d);
        check(d, e);
    endtask : expect16

    // ****************************************
    // Pin and acknowledge drivers
    // ****************************************
    task automatic drive_in(input int sel, input logic lv, input int hold);
        @(posedge MCLK);
        case (sel)
            IN_EXT: ext_pin <= lv;
            IN_PIN: cap_pin <= lv;
            default: comp_out <= lv;
        endcase
        repeat (hold) @(posedge MCLK);
    endtask : drive_in

    task automatic ext_ticks(input int n);
        repeat (n)
        begin
            drive_in(IN_EXT, 1'b1, 4);
            drive_in(IN_EXT, 1'b0, 4);
        end
        repeat (6) @(posedge MCLK);
    endtask : ext_ticks

    task automatic ack(input logic is_capt);
        @(posedge MCLK);
        ovf_ack <= ~is_capt;
        capt_ack <= is_capt;
        @(posedge MCLK);
        ovf_ack <= 1'b0;
        capt_ack <= 1'b0;
        #1;
    endtask : ack

    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        v = 16'($urandom(36107));
        repeat (3) @(posedge MCLK);
        RST_B <= 1'b1;
        @(posedge MCLK);
        #1;
        check(pins(), 16'h0004);
        expect16(OFS_CNT_LO, 16'h0000);
        expect8(4'hf, 8'h00);
        cpu_u.wr16(OFS_CAP_LO, 16'($urandom));
        expect16(OFS_CAP_LO, 16'h0000);
        vals = '{16'hffff, 16'h0000, 16'($urandom), 16'($urandom)};
        foreach (vals[i])
        begin
            cpu_u.wr16(OFS_CNT_LO, vals[i]);
            check(pins(), exp_pins(vals[i], 2'b00));
            repeat ($urandom % 8) @(posedge MCLK);
            expect16(OFS_CNT_LO, vals[i]);
        end
        // Wrap through the top on rising, then falling external edges
        cpu_u.wr(OFS_MASK, 8'h03);
        cpu_u.wr16(OFS_CNT_LO, 16'hfffd);
        cpu_u.wr(OFS_CTRL_B, {5'h00, CS_EXT_RISE});
        ext_ticks(5);
        cpu_u.wr(OFS_CTRL_B, {5'h00, CS_EXT_FALL});
        ext_ticks(3);
        cpu_u.wr(OFS_CTRL_B, 8'h00);
        expect16(OFS_CNT_LO, 16'h0005);
        expect8(OFS_FLAGS, 8'h01);
        check(pins(), 16'h0002);
        ack(1'b0);
        expect8(OFS_FLAGS, 8'h00);
        // Capture on the pin, rising edge
        cpu_u.wr16(OFS_CNT_LO, v);
        cpu_u.wr(OFS_CTRL_B, 8'h40);
        drive_in(IN_PIN, 1'b1, 12);
        expect8(OFS_FLAGS, 8'h02);
        check(pins(), exp_pins(v, 2'b01));
        expect16(OFS_CAP_LO, v);
        ack(1'b1);
        expect8(OFS_FLAGS, 8'h00);
        // A second event overwrites the earlier value, falling edge
        t = 16'($urandom);
        cpu_u.wr16(OFS_CNT_LO, t);
        cpu_u.wr(OFS_CTRL_B, 8'h00);
        drive_in(IN_PIN, 1'b0, 12);
        expect16(OFS_CAP_LO, t);
        cpu_u.clear_flags(8'h02);
        expect8(OFS_FLAGS, 8'h00);
        // Comparator as trigger source
        cpu_u.wr(OFS_CTRL_B, 8'h40);
        cpu_u.wr(OFS_SRC, 8'h01);
        cpu_u.clear_flags(8'h02);
        cpu_u.wr16(OFS_CNT_LO, v ^ 16'h5a5a);
        drive_in(IN_COMP, 1'b1, 12);
        expect8(OFS_FLAGS, 8'h02);
        expect16(OFS_CAP_LO, v ^ 16'h5a5a);
        // Filter rejects a three-sample pulse and passes a steady level
        cpu_u.wr(OFS_CTRL_B, 8'hc0);
        cpu_u.wr(OFS_SRC, 8'h00);
        repeat (12) @(posedge MCLK);
        cpu_u.clear_flags(8'h02);
        drive_in(IN_PIN, 1'b1, 2);
        drive_in(IN_PIN, 1'b0, 15);
        expect8(OFS_FLAGS, 8'h00);
        drive_in(IN_PIN, 1'b1, 16);
        expect8(OFS_FLAGS, 8'h02);
        cpu_u.wr(OFS_MASK, 8'h01);
        check(pins(), exp_pins(v ^ 16'h5a5a, 2'b00));
        // Capture register as top in fast mode
        cpu_u.wr(OFS_CTRL_B, 8'h18);
        cpu_u.wr(OFS_CTRL_A, 8'h02);
        t = 16'(8 + $urandom % 32);
        cpu_u.wr16(OFS_CAP_LO, t);
        expect16(OFS_CAP_LO, t);
        cpu_u.wr16(OFS_CNT_LO, t);
        cpu_u.clear_flags(8'h03);
        drive_in(IN_PIN, 1'b0, 12);
        expect8(OFS_FLAGS, 8'h00);
        check(pins(), 16'h0008);
        cpu_u.wr(OFS_CTRL_B, 8'h1f);
        ext_ticks(1);
        cpu_u.wr(OFS_CTRL_B, 8'h18);
        expect16(OFS_CNT_LO, 16'h0000);
        expect8(OFS_FLAGS, 8'h01);
        check(pins(), 16'h0006);
        // Dual slope to the capture top on the system clock, counter written while running
        cpu_u.clear_flags(8'h03);
        cpu_u.wr(OFS_CTRL_B, 8'h11);
        cpu_u.wr16(OFS_CNT_LO, t - 16'h0001);
        repeat (t + 1) @(posedge MCLK);
        cpu_u.wr(OFS_CTRL_B, 8'h10);
        expect16(OFS_CNT_LO, 16'h0002);
        expect8(OFS_FLAGS, 8'h01);
        final_report();
    end

    initial
    begin
        #100us;
        fails++;
        final_report();
    end

endmodule : tb_top
